// ---- verilog/section_builder_consts.svh ----
`ifndef SECTION_BUILDER_CONSTS_SVH
`define SECTION_BUILDER_CONSTS_SVH

// Section and packet framing
`define TABLE_ID_AGG 8'hA7
`define TS_SYNC_BYTE 8'h47
`define TS_STUFF_BYTE 8'hFF
`define TS_PACKET_LAST 8'd187
`define TS_HEADER_LAST 8'd3
`define TS_POINTER_POS 8'd4
`define SECTION_HDR_BYTES 4'd8
`define CRC_POLY 32'h04C1_1DB7
`define CRC_INIT 32'hFFFF_FFFF

// Slot entry word layout (LSB positions)
`define SW_SLOT_LSB 0
`define SW_TFLAG_BIT 11
`define SW_PFLAG_BIT 12
`define SW_FFLAG_BIT 13
`define SW_TYPE_LSB 14
`define SW_SCALE_LSB 16
`define SW_TIMING_LSB 19
`define SW_ABS_BIT 27
`define SW_EBN0_LSB 28
`define SW_POWER_LSB 35
`define SW_FREQ_LSB 42
`define SW_WIDTH 58

// Frame entry word layout
`define FW_FRAME_LSB 0
`define FW_SLOTS_LSB 5

// Buffering
`define WORD_FIFO_DEPTH 32

`endif

// ---- verilog/section_builder_pkg.sv ----
package section_builder_pkg;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_SF = 3'b001,
    PH_FRAME = 3'b010,
    PH_SLOT = 3'b011,
    PH_CRC = 3'b100,
    PH_FIN = 3'b101,
    PH_STUFF = 3'b110
  } phase_type;

  typedef struct packed {
    phase_type phase;
    logic [63:0] field_buf;
    logic [3:0] field_cnt;
    logic [4:0] frames_left;
    logic [10:0] slots_left;
    logic [7:0] sf_label;
    logic [15:0] sf_count;
    logic [31:0] crc;
    logic [7:0] pos;
    logic [3:0] cc;
    logic pusi;
    logic [7:0] out_data;
    logic out_valid;
    logic busy;
  } builder_state_type;

endpackage

// ---- verilog/word_fifo.sv ----
`timescale 1ns/1ps
`include "section_builder_consts.svh"

module word_fifo #(
  parameter int WIDTH = `SW_WIDTH,
  parameter int DEPTH = `WORD_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("word_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic ready;
  } fifo_state_type;

  fifo_state_type state_r;
  fifo_state_type state_nxt;
  logic push;
  logic pop;
  logic [AW:0] fill;

  assign push = in_valid && state_r.ready;
  assign pop = out_valid && out_ready;
  assign in_ready = state_r.ready;
  assign out_valid = state_r.wr_ptr != state_r.rd_ptr;
  assign out_data = state_r.mem[state_r.rd_ptr[AW-1:0]];

  always_comb begin
    state_nxt = state_r;
    if (push) begin
      state_nxt.mem[state_r.wr_ptr[AW-1:0]] = in_data;
      state_nxt.wr_ptr = state_r.wr_ptr + 1'b1;
    end
    if (pop) begin
      state_nxt.rd_ptr = state_r.rd_ptr + 1'b1;
    end
    fill = state_nxt.wr_ptr - state_nxt.rd_ptr;
    // Registered so the source sees ready straight from a flop
    state_nxt.ready = fill != DEPTH[AW:0];
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= '0;
      state_r.ready <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end
endmodule

// ---- verilog/measurement_section_builder.sv ----
// Notes on behaviour
// - Section opens with 64-bit private header
// - Then 8-bit superframe label
// - Then 16-bit wrapping superframe counter
// - Frame count minus one, 3 reserved bits
// - Frame entry opens with 5-bit index
// - Slot count minus one, 5 reserved bits
// - Slot entry opens with 11-bit index
// - Presence flags: timing, power, frequency
// - Then 2-bit burst category code
// - Then 3-bit timing scale exponent
// - Exponent forced 000 without timing
// - Timing: 8-bit signed 27 MHz offset
// - Power present: absolute-power flag first
// - Power present: 7-bit signed Eb/N0
// - Absolute-power flag set: reserved bit, 7-bit signed power
// - Frequency present: 16-bit signed error
// - No frequency correction: field all zeros
// - Entry reserved bits lead, sent as zero; section header reserved bits are ones
// - Sections ride in packets on given PID
// - Section carries this table's identifier
`timescale 1ns/1ps
`include "section_builder_consts.svh"

module measurement_section_builder #(
  parameter int WORD_W = `SW_WIDTH,
  parameter int FIFO_DEPTH = `WORD_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [7:0] superframe_label,
  input wire logic [15:0] superframe_count,
  input wire logic [4:0] frame_count_m1,
  input wire logic [11:0] section_length,
  input wire logic [15:0] table_ext,
  input wire logic [4:0] version,
  input wire logic [7:0] section_number,
  input wire logic [7:0] last_section_number,
  input wire logic [12:0] pid,
  input wire logic no_freq_correction,
  input wire logic [WORD_W-1:0] word_data,
  input wire logic word_valid,
  output logic word_ready,
  output logic [7:0] ts_data,
  output logic ts_valid,
  input wire logic ts_ready,
  output logic busy
);

  generate
    if (WORD_W < `SW_WIDTH) begin : g_bad_width
      $error("measurement_section_builder word width too small");
    end
  endgenerate

  section_builder_pkg::builder_state_type state_r;
  section_builder_pkg::builder_state_type state_nxt;
  logic [WORD_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;

  // Entries pass through the buffer; a stalled packet output stops the
  // pops, the buffer fills and word_ready drops back to the source.
  word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_word_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_data(word_data),
    .in_valid(word_valid),
    .in_ready(word_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  function automatic logic [31:0] crc_byte(
    input logic [31:0] crc_in,
    input logic [7:0] data
  );
    logic [31:0] c;
    logic fb;
    c = crc_in;
    for (int i = 7; i >= 0; i--) begin
      fb = c[31] ^ data[i];
      c = {c[30:0], 1'b0};
      if (fb) begin
        c = c ^ `CRC_POLY;
      end
    end
    return c;
  endfunction

  // Places one byte after the n bytes already queued, MSB first
  function automatic logic [63:0] put_byte(
    input logic [63:0] acc,
    input logic [3:0] n,
    input logic [7:0] val
  );
    logic [63:0] shifted;
    shifted = {val, 56'h0} >> (8 * n);
    return acc | shifted;
  endfunction

  always_comb begin
    logic [63:0] b;
    logic [3:0] n;
    logic tflag;
    logic pflag;
    logic fflag;
    logic absflag;
    logic [2:0] scale;
    logic [15:0] freq;
    logic adv;
    logic emit;
    logic [7:0] ebyte;
    b = '0;
    n = '0;
    tflag = fifo_data[`SW_TFLAG_BIT];
    pflag = fifo_data[`SW_PFLAG_BIT];
    fflag = fifo_data[`SW_FFLAG_BIT];
    absflag = fifo_data[`SW_ABS_BIT];
    scale = fifo_data[`SW_SCALE_LSB +: 3];
    freq = fifo_data[`SW_FREQ_LSB +: 16];
    adv = !state_r.out_valid || ts_ready;
    emit = 1'b0;
    ebyte = '0;
    fifo_pop = 1'b0;
    state_nxt = state_r;

    if (ts_ready) begin
      state_nxt.out_valid = 1'b0;
    end

    // Loading the next group of section fields
    if (state_r.phase == section_builder_pkg::PH_IDLE) begin
      if (start) begin
        state_nxt.phase = section_builder_pkg::PH_SF;
        state_nxt.busy = 1'b1;
        state_nxt.pos = '0;
        state_nxt.pusi = 1'b1;
        state_nxt.crc = `CRC_INIT;
        state_nxt.sf_label = superframe_label;
        state_nxt.sf_count = superframe_count;
        state_nxt.frames_left = frame_count_m1;
        state_nxt.field_buf = {
          `TABLE_ID_AGG,
          1'b1, 1'b0, 2'b11, section_length[11:8],
          section_length[7:0],
          table_ext,
          2'b11, version, 1'b1,
          section_number,
          last_section_number
        };
        state_nxt.field_cnt = `SECTION_HDR_BYTES;
      end
    end else if (state_r.field_cnt == 4'd0) begin
      case (state_r.phase)
        section_builder_pkg::PH_SF: begin
          b = put_byte(b, n, state_r.sf_label);
          n = n + 4'd1;
          b = put_byte(b, n, state_r.sf_count[15:8]);
          n = n + 4'd1;
          b = put_byte(b, n, state_r.sf_count[7:0]);
          n = n + 4'd1;
          b = put_byte(b, n, {3'b000, state_r.frames_left});
          n = n + 4'd1;
          state_nxt.phase = section_builder_pkg::PH_FRAME;
        end
        section_builder_pkg::PH_FRAME: begin
          if (fifo_valid) begin
            fifo_pop = 1'b1;
            b = put_byte(b, n,
              {3'b000, fifo_data[`FW_FRAME_LSB +: 5]});
            n = n + 4'd1;
            b = put_byte(b, n,
              {5'b00000, fifo_data[`FW_SLOTS_LSB + 8 +: 3]});
            n = n + 4'd1;
            b = put_byte(b, n, fifo_data[`FW_SLOTS_LSB +: 8]);
            n = n + 4'd1;
            state_nxt.slots_left = fifo_data[`FW_SLOTS_LSB +: 11];
            state_nxt.phase = section_builder_pkg::PH_SLOT;
          end
        end
        section_builder_pkg::PH_SLOT: begin
          if (fifo_valid) begin
            fifo_pop = 1'b1;
            b = put_byte(b, n,
              {5'b00000, fifo_data[`SW_SLOT_LSB + 8 +: 3]});
            n = n + 4'd1;
            b = put_byte(b, n, fifo_data[`SW_SLOT_LSB +: 8]);
            n = n + 4'd1;
            if (!tflag) begin
              scale = 3'b000;
            end
            b = put_byte(b, n, {tflag, pflag, fflag,
              fifo_data[`SW_TYPE_LSB +: 2],
              scale});
            n = n + 4'd1;
            if (tflag) begin
              b = put_byte(b, n, fifo_data[`SW_TIMING_LSB +: 8]);
              n = n + 4'd1;
            end
            if (pflag) begin
              b = put_byte(b, n,
                {absflag, fifo_data[`SW_EBN0_LSB +: 7]});
              n = n + 4'd1;
              if (absflag) begin
                b = put_byte(b, n,
                  {1'b0, fifo_data[`SW_POWER_LSB +: 7]});
                n = n + 4'd1;
              end
            end
            if (fflag) begin
              if (no_freq_correction) begin
                freq = 16'h0000;
              end
              b = put_byte(b, n, freq[15:8]);
              n = n + 4'd1;
              b = put_byte(b, n, freq[7:0]);
              n = n + 4'd1;
            end
            if (state_r.slots_left != 11'd0) begin
              state_nxt.slots_left = state_r.slots_left - 11'd1;
            end else if (state_r.frames_left != 5'd0) begin
              state_nxt.frames_left = state_r.frames_left - 5'd1;
              state_nxt.phase = section_builder_pkg::PH_FRAME;
            end else begin
              state_nxt.phase = section_builder_pkg::PH_CRC;
            end
          end
        end
        section_builder_pkg::PH_CRC: begin
          // All section bytes before this point are already in crc
          b = {state_r.crc, 32'h0000_0000};
          n = 4'd4;
          state_nxt.phase = section_builder_pkg::PH_FIN;
        end
        section_builder_pkg::PH_FIN: begin
          state_nxt.phase = section_builder_pkg::PH_STUFF;
        end
        default: begin
          n = 4'd0;
        end
      endcase
      state_nxt.field_buf = b;
      state_nxt.field_cnt = n;
    end

    // Packet assembly: header, pointer, section bytes, stuffing
    if (adv && state_r.phase != section_builder_pkg::PH_IDLE) begin
      if (state_r.pos <= `TS_HEADER_LAST) begin
        emit = 1'b1;
        case (state_r.pos[1:0])
          2'b00: ebyte = `TS_SYNC_BYTE;
          2'b01: ebyte = {1'b0, state_r.pusi, 1'b0, pid[12:8]};
          2'b10: ebyte = pid[7:0];
          default: ebyte = {2'b00, 2'b01, state_r.cc};
        endcase
      end else if (state_r.pos == `TS_POINTER_POS && state_r.pusi) begin
        // Section starts right after the pointer
        emit = 1'b1;
        ebyte = 8'h00;
      end else if (state_r.field_cnt != 4'd0) begin
        emit = 1'b1;
        ebyte = state_r.field_buf[63:56];
        state_nxt.field_buf = {state_r.field_buf[55:0], 8'h00};
        state_nxt.field_cnt = state_r.field_cnt - 4'd1;
        if (state_r.phase != section_builder_pkg::PH_FIN) begin
          state_nxt.crc = crc_byte(state_r.crc, ebyte);
        end
      end else if (state_r.phase == section_builder_pkg::PH_STUFF) begin
        emit = 1'b1;
        ebyte = `TS_STUFF_BYTE;
      end
    end

    if (emit) begin
      state_nxt.out_data = ebyte;
      state_nxt.out_valid = 1'b1;
      if (state_r.pos == `TS_PACKET_LAST) begin
        state_nxt.pos = '0;
        state_nxt.cc = state_r.cc + 4'd1;
        state_nxt.pusi = 1'b0;
        if (state_r.phase == section_builder_pkg::PH_STUFF) begin
          state_nxt.phase = section_builder_pkg::PH_IDLE;
          state_nxt.busy = 1'b0;
        end
      end else begin
        state_nxt.pos = state_r.pos + 8'd1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign ts_data = state_r.out_data;
  assign ts_valid = state_r.out_valid;
  assign busy = state_r.busy;

endmodule

// ---- test/section_builder_checker.sv ----
`timescale 1ns/1ps
module section_builder_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [12:0] pid,
  input wire logic [7:0] ts_data,
  input wire logic ts_valid,
  input wire logic ts_ready,
  input wire logic busy
);
  logic [7:0] pos_r;
  logic [3:0] cc_r;
  logic pusi_r;
  wire logic take = ts_valid && ts_ready;
  // Byte position in packet, so payload bytes equal to 47 are not syncs
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pos_r <= 8'h00;
      cc_r <= 4'h0;
      pusi_r <= 1'b0;
    end else if (take) begin
      pos_r <= (pos_r == 8'hBB) ? 8'h00 : pos_r + 8'h01;
      if (pos_r == 8'hBB) cc_r <= cc_r + 4'h1;
      if (pos_r == 8'h01) pusi_r <= ts_data[6];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence start_taken;
    start && !busy;
  endsequence
  sequence sync_shown;
    busy && ts_valid && ts_data == 8'h47;
  endsequence
  start_sync_a: assert property (start_taken |-> ##2 sync_shown)
    else $error("no sync byte after start");
  hold_data_a: assert property (ts_valid && !ts_ready |=>
    ts_valid && $stable(ts_data)) else $error("byte not held");
  // Last stuffing byte may still stand after busy drops
  idle_quiet_a: assert property (!busy && !ts_valid |=> !ts_valid)
    else $error("valid while idle");
  sync_pos_a: assert property (take && pos_r == 8'h00 |->
    ts_data == 8'h47) else $error("bad sync byte");
  pid_high_a: assert property (take && pos_r == 8'h01 |->
    !ts_data[7] && ts_data[4:0] == pid[12:8]) else $error("bad pid hi");
  pid_low_a: assert property (take && pos_r == 8'h02 |->
    ts_data == pid[7:0]) else $error("bad pid lo");
  cont_count_a: assert property (take && pos_r == 8'h03 |->
    ts_data == {4'h1, cc_r}) else $error("bad counter byte");
  pointer_zero_a: assert property (take && pos_r == 8'h04 && pusi_r |->
    ts_data == 8'h00) else $error("bad pointer");
  table_id_a: assert property (take && pos_r == 8'h05 && pusi_r |->
    ts_data == 8'hA7) else $error("bad table id");
  packet_end_a: assert property ($fell(busy) |->
    ts_valid && pos_r == 8'hBB)
    else $error("busy fell inside packet");
endmodule
bind measurement_section_builder section_builder_checker i_chk (
  .clk_sys(clk_sys),
  .sys_rst(sys_rst),
  .start(start),
  .pid(pid),
  .ts_data(ts_data),
  .ts_valid(ts_valid),
  .ts_ready(ts_ready),
  .busy(busy)
);

// ---- test/ground_terminal_model.sv ----
`timescale 1ns/1ps
module ground_terminal_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic [7:0] ts_data,
  input wire logic ts_valid,
  output logic ts_ready
);
  logic [7:0] cap [0:1023];
  int count = 0;
  logic [1:0] tick_r = 2'b00;
  always_ff @(posedge clk_sys) begin
    tick_r <= tick_r + 2'b01;
    if (ts_valid && ts_ready && !sys_rst) begin
      cap[count] <= ts_data;
      count <= count + 1;
    end
  end
  // Slow mode stalls three cycles in four to stress back-pressure
  assign ts_ready = !slow || (tick_r == 2'b11);
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 0, sys_rst = 1, start = 0, nf = 0, slow = 0;
  logic [7:0] superframe_label = 0, ts_data;
  logic [15:0] superframe_count = 0;
  logic [4:0] frame_count_m1 = 0;
  logic [11:0] section_length = 0;
  logic [12:0] pid = 13'h1A5B;
  logic [15:0] table_ext = 16'h1234;
  logic [4:0] version = 5'h03;
  logic [57:0] word_data = 0;
  logic word_valid = 0, word_ready, ts_valid, ts_ready, busy;
  logic [7:0] sec[$], exp_q[$];
  logic [57:0] wq[$];
  logic [3:0] cc = 0;
  int fails = 0, samples_checked = 0;
  always #4 clk_sys = ~clk_sys;
  measurement_section_builder i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .start(start), .superframe_label(superframe_label),
    .superframe_count(superframe_count), .frame_count_m1(frame_count_m1),
    .section_length(section_length), .table_ext(table_ext),
    .version(version), .section_number(8'h00), .last_section_number(8'h00),
    .pid(pid), .no_freq_correction(nf), .word_data(word_data),
    .word_valid(word_valid), .word_ready(word_ready), .ts_data(ts_data),
    .ts_valid(ts_valid), .ts_ready(ts_ready), .busy(busy));
  ground_terminal_model i_sink (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .slow(slow), .ts_data(ts_data), .ts_valid(ts_valid),
    .ts_ready(ts_ready));
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [57:0] slot_word(input logic [4:0] i);
    return {16'h8000 + 16'(i) * 16'h0101, 7'(i * 3), 7'h40 | 7'(i), i[3],
      8'h80 + 8'(i), 3'(i + 1), i[4:3], i[2], i[1], i[0], 6'h00, i};
  endfunction
  function automatic logic [31:0] crc32(input logic [7:0] q[$]);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    foreach (q[i]) for (int j = 7; j >= 0; j--)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ q[i][j]) ? 32'h04C1_1DB7 : 32'h0);
    return c;
  endfunction
  task automatic add_frame(input logic [4:0] idx, input int n, input int b);
    logic [57:0] w;
    wq.push_back({42'h0, 11'(n - 1), idx});
    sec.push_back({3'b000, idx});
    sec.push_back({5'b00000, 3'((n - 1) >> 8)});
    sec.push_back(8'(n - 1));
    for (int k = 0; k < n; k++) begin
      w = slot_word(5'(b + k));
      wq.push_back(w);
      sec.push_back({5'b00000, w[10:8]});
      sec.push_back(w[7:0]);
      sec.push_back({w[11], w[12], w[13], w[15:14], w[11] ? w[18:16] : 3'b0});
      if (w[11]) sec.push_back(w[26:19]);
      if (w[12]) sec.push_back({w[27], w[34:28]});
      if (w[12] && w[27]) sec.push_back({1'b0, w[41:35]});
      if (w[13]) sec.push_back(nf ? 8'h00 : w[57:50]);
      if (w[13]) sec.push_back(nf ? 8'h00 : w[49:42]);
    end
  endtask
  task automatic run_sec();
    logic [31:0] c;
    int i, n, b;
    b = i_sink.count;
    section_length <= 12'(sec.size() + 1);
    sec[1] = {4'hB, 4'((sec.size() + 1) >> 8)};
    sec[2] = 8'(sec.size() + 1);
    c = crc32(sec);
    for (int k = 3; k >= 0; k--) sec.push_back(c[8*k+:8]);
    exp_q.delete();
    i = 0;
    while (i < sec.size()) begin
      exp_q.push_back(8'h47);
      exp_q.push_back({1'b0, i == 0, 1'b0, pid[12:8]});
      exp_q.push_back(pid[7:0]);
      exp_q.push_back({4'h1, cc});
      n = (i == 0) ? 5 : 4;
      if (i == 0) exp_q.push_back(8'h00);
      cc++;
      for (; n < 188; n++) begin
        exp_q.push_back(i < sec.size() ? sec[i] : 8'hFF);
        i++;
      end
    end
    foreach (wq[k]) begin
      word_data <= wq[k];
      word_valid <= 1;
      @(posedge clk_sys);
      while (word_ready !== 1'b1) @(posedge clk_sys);
    end
    word_valid <= 0;
    repeat (2) @(posedge clk_sys);
    if (wq.size() == 32) chk(word_ready, 0);
    start <= 1;
    @(posedge clk_sys);
    start <= 0;
    repeat (50) @(posedge clk_sys);
    start <= 1;
    @(posedge clk_sys);
    start <= 0;
    for (n = 0; n < 9000 && busy !== 1'b0; n++) @(posedge clk_sys);
    // Slow sink may take a few cycles for the last byte
    repeat (8) @(posedge clk_sys);
    chk(i_sink.count - b, exp_q.size());
    foreach (exp_q[k]) chk(i_sink.cap[b + k], exp_q[k]);
  endtask
  task automatic begin_sec(input logic [7:0] l, input logic [15:0] s,
                           input logic [4:0] f);
    superframe_label <= l;
    superframe_count <= s;
    frame_count_m1 <= f;
    sec = '{8'hA7, 8'h00, 8'h00, 8'h12, 8'h34, 8'hC7, 8'h00, 8'h00,
      l, s[15:8], s[7:0], {3'b000, f}};
    wq.delete();
  endtask
  initial begin
    #200_000;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 0;
    @(posedge clk_sys);
    slow <= 1;
    begin_sec(8'h5A, 16'hFFFF, 5'h00);
    add_frame(5'h03, 31, 0);
    run_sec();
    @(posedge clk_sys);
    nf <= 1;
    slow <= 0;
    @(posedge clk_sys);
    begin_sec(8'hC3, 16'h0000, 5'h01);
    add_frame(5'h00, 1, 4);
    add_frame(5'h1F, 1, 7);
    run_sec();
    wrap_up();
  end
endmodule
